// *** bench/i2c_tac_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module i2c_tac_checker #(
    parameter int AW = 8
) (
    input wire logic mclk,
    input wire logic lclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic scl_i,
    input wire logic sda_oe,
    input wire logic internal_read_allow,
    input wire logic internal_write_allow,
    input wire logic peripheral_allow,
    input wire logic access_start
);
    logic ctl_wr;
    logic ctl_rd;
    assign ctl_wr = ce && reg_wr && reg_addr == '0;
    assign ctl_rd = ce && reg_rd && reg_addr == '0;

    enable_gates_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_wr ##1 ce |=> peripheral_allow == $past(reg_wdata[28], 2))
        else $error("peripheral allow wrong");
    read_allow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_wr ##1 ce |=> internal_read_allow == $past(reg_wdata[31] && reg_wdata[28], 2))
        else $error("read allow wrong");
    write_allow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_wr ##1 ce |=> internal_write_allow == $past(reg_wdata[30] && reg_wdata[28], 2))
        else $error("write allow wrong");
    high_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_wr ##1 ctl_rd |=> reg_rdata[6:2] == $past(reg_wdata[6:2], 2))
        else $error("upper address bits not written");
    low_locked_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_rd ##1 (ctl_wr && !reg_wdata[24]) ##1 ctl_rd |=>
        reg_rdata[1:0] == $past(reg_rdata[1:0], 2))
        else $error("locked low bits changed");
    low_unlocked_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctl_wr && reg_wdata[24]) ##1 ctl_rd |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
        else $error("unlocked low bits not written");
    reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctl_rd |=> reg_rdata[27:25] == 3'h0 && reg_rdata[23:7] == 17'h0)
        else $error("reserved control bits set");
    start_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
        access_start |=> !access_start)
        else $error("access start longer than one cycle");
    start_enabled_a: assert property (@(posedge mclk) disable iff (!rst_n)
        access_start |-> peripheral_allow)
        else $error("access started while disabled");
    ack_rise_low_a: assert property (@(posedge lclk) disable iff (!rst_n)
        $rose(sda_oe) |-> !scl_i)
        else $error("data pulled while clock high");
    ack_hold_a: assert property (@(posedge lclk) disable iff (!rst_n)
        scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("data moved while clock high");
endmodule

bind i2c_tac_top i2c_tac_checker #(.AW(AW)) u_checker (
    .mclk(mclk), .lclk(lclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_i(scl_i), .sda_oe(sda_oe), .internal_read_allow(internal_read_allow),
    .internal_write_allow(internal_write_allow), .peripheral_allow(peripheral_allow),
    .access_start(access_start)
);

`default_nettype wire

// *** bench/i2c_tac_master.sv ***
`timescale 1ns/10ps
`default_nettype none

module i2c_tac_master (
    input wire logic lclk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Quarter bit: covers the input sync flops and the ack delay
    task automatic q();
        repeat (8) @(posedge lclk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic frame(input logic [7:0] b, output logic ack, output logic [7:0] rx);
        logic r;
        logic [7:0] dat;
        dat = 8'h5a;
        rx = 8'h00;
        sda_m <= 1'b0;
        q();
        scl <= 1'b0;
        q();
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
        if (ack) begin
            for (int i = 7; i >= 0; i--) begin
                bit_io(b[0] | dat[i], r);
                rx[i] = r;
            end
            bit_io(1'b1, r);
            if (!b[0]) rx = {7'h0, !r};
        end
        sda_m <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_m <= 1'b1;
        q();
    endtask
endmodule

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic alert_event = 1'b0;
    logic [1:0] addr_strap = 2'b00;
    logic [31:0] reg_rdata;
    logic scl, sda_m, sda_w, sda_o, sda_oe, ird, iwr, per, acc_start, acc_read;
    logic [31:0] seed = 32'h9d95;
    logic [31:0] m_ctrl;
    logic [31:0] pend_exp;
    logic pend = 1'b0;
    logic m_flag = 1'b0;
    logic m_dir = 1'b0;
    int mismatches = 0;
    int n_checks = 0;
    int n_starts = 0;

    always #5 mclk = ~mclk;
    initial begin
        #3.3;
        forever #15 lclk = ~lclk;
    end
    // Pull-up: released line reads high
    assign sda_w = sda_m & ~sda_oe;
    always @(posedge mclk) if (acc_start === 1'b1) n_starts++;

    i2c_tac_top i_i2c_tac_top (.mclk(mclk), .lclk(lclk), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .addr_strap(addr_strap), .alert_event(alert_event),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .internal_read_allow(ird), .internal_write_allow(iwr), .peripheral_allow(per),
        .access_start(acc_start), .access_read(acc_read));
    i2c_tac_master u_master (.lclk(lclk), .sda(sda_w), .scl(scl), .sda_m(sda_m));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] kind(input logic [7:0] b);
        if (m_ctrl[29] && m_flag && b == 8'h19) return 2'd2;
        if (b[7:1] == 7'h00 || (m_ctrl[29] && b[7:1] == 7'h0c)) return 2'd0;
        return (m_ctrl[28] && b[7:1] == m_ctrl[6:0]) ? 2'd1 : 2'd0;
    endfunction
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Called just after a clock edge; read data is checked at the following call
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        if (pend) check_word(reg_rdata, pend_exp);
        pend = r;
        pend_exp = (ce && a == 8'h00) ? m_ctrl : 32'h0;
        if (ce && a == 8'h04) pend_exp = {28'h0, m_dir, addr_strap, m_flag};
        if (ce && w && a == 8'h00) begin
            m_ctrl = (d & 32'hf100_007c) | {30'h0, d[24] ? d[1:0] : m_ctrl[1:0]};
        end
    endtask
    task automatic setctl(input logic [31:0] d);
        bus(1'b1, 1'b0, 8'h00, d);
        bus(1'b0, 1'b1, 8'h00, 32'h0);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        check_word({29'h0, ird, iwr, per}, {29'h0, m_ctrl[31] & m_ctrl[28],
            m_ctrl[30] & m_ctrl[28], m_ctrl[28]});
    endtask
    task automatic alert();
        alert_event <= 1'b1;
        @(posedge mclk);
        alert_event <= 1'b0;
        @(posedge mclk);
        m_flag = 1'b1;
    endtask
    task automatic try(input logic [7:0] b);
        logic ack;
        logic [7:0] rx;
        logic [1:0] k;
        logic [7:0] e_rx;
        int s0;
        k = kind(b);
        e_rx = (k == 2'd2) ? {m_ctrl[6:0], 1'b0} : (k == 2'd0) ? 8'h00 : b[0] ? 8'hff : 8'h01;
        s0 = n_starts;
        // Let configuration cross into the link domain
        repeat (20) @(posedge lclk);
        u_master.frame(b, ack, rx);
        repeat (10) @(posedge mclk);
        check_word({31'h0, ack}, {31'h0, k != 2'd0});
        check_word({24'h0, rx}, {24'h0, e_rx});
        check_word(n_starts - s0, (k == 2'd1) ? 1 : 0);
        if (k == 2'd2) m_flag = 1'b0;
        if (k == 2'd1) begin
            m_dir = b[0];
            check_word({31'h0, acc_read}, {31'h0, b[0]});
        end
    endtask

    initial begin
        #1ms;
        mismatches++;
        print_verdict();
    end
    initial begin
        seed = lfsr(seed);
        addr_strap = seed[1:0];
        m_ctrl = 32'hd000_0030 | {30'h0, seed[1:0]};
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        bus(1'b0, 1'b1, 8'h00, 32'h0);
        bus(1'b0, 1'b1, 8'h04, 32'h0);
        bus(1'b0, 1'b1, 8'h0c, 32'h0);
        setctl(m_ctrl & 32'hffff_fffc);
        try({m_ctrl[6:0], 1'b0});
        try({m_ctrl[6:0], 1'b1});
        try({m_ctrl[6:0] ^ 7'h01, 1'b0});
        try(8'h00);
        try(8'h01);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            bus(1'b0, 1'b1, 8'h00, 32'h0);
            setctl(seed | 32'h0000_0040);
            try({m_ctrl[6:0], seed[8]});
        end
        setctl(32'hc000_0040);
        try({m_ctrl[6:0], 1'b0});
        setctl(32'h2000_0040);
        try(8'h19);
        alert();
        bus(1'b0, 1'b1, 8'h04, 32'h0);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        try(8'h19);
        bus(1'b0, 1'b1, 8'h04, 32'h0);
        setctl(32'h3100_000c);
        try(8'h18);
        alert();
        try(8'h19);
        setctl(32'h1000_000c);
        try(8'h18);
        ce <= 1'b0;
        bus(1'b1, 1'b0, 8'h00, 32'h0);
        ce <= 1'b1;
        bus(1'b0, 1'b1, 8'h00, 32'h0);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        print_verdict();
    end
endmodule

`default_nettype wire

// *** design/i2c_tac_bytes.sv ***
`timescale 1ns/10ps
`default_nettype none

// Bit level engine: start/stop, byte shift in/out, acknowledge slot.
module i2c_tac_bytes (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    input wire logic tx_en,
    input wire logic [7:0] tx_data,
    output logic start_p,
    output logic stop_p,
    output logic byte_p,
    output logic slot_end_p,
    output logic master_nack,
    output logic [7:0] rx_byte,
    output logic sda_oe
);
    logic scl_q;
    logic sda_q;
    logic active;
    logic in_slot;
    logic [3:0] cnt;
    logic [7:0] sh;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            active <= 1'b0;
            in_slot <= 1'b0;
            cnt <= 4'h0;
            sh <= 8'h00;
            rx_byte <= 8'h00;
            master_nack <= 1'b0;
            sda_oe <= 1'b0;
            start_p <= 1'b0;
            stop_p <= 1'b0;
            byte_p <= 1'b0;
            slot_end_p <= 1'b0;
        end else if (run) begin
            scl_q <= scl;
            sda_q <= sda;
            start_p <= 1'b0;
            stop_p <= 1'b0;
            byte_p <= 1'b0;
            slot_end_p <= 1'b0;
            if (scl && scl_q && sda_q && !sda) begin
                active <= 1'b1;
                in_slot <= 1'b0;
                cnt <= 4'h0;
                sda_oe <= 1'b0;
                start_p <= 1'b1;
            end else if (scl && scl_q && !sda_q && sda) begin
                active <= 1'b0;
                in_slot <= 1'b0;
                sda_oe <= 1'b0;
                stop_p <= 1'b1;
            end else if (active && scl && !scl_q) begin
                if (in_slot) begin
                    master_nack <= sda;
                end else if (cnt < 4'h8) begin
                    rx_byte <= {rx_byte[6:0], sda};
                    cnt <= cnt + 4'h1;
                    byte_p <= (cnt == 4'h7);
                end
            end else if (active && !scl && scl_q) begin
                if (in_slot) begin
                    in_slot <= 1'b0;
                    cnt <= 4'h0;
                    slot_end_p <= 1'b1;
                    sh <= {tx_data[6:0], 1'b0};
                    sda_oe <= tx_en && !tx_data[7];
                end else if (cnt == 4'h8) begin
                    in_slot <= 1'b1;
                    // Ack only; our sent bytes drop ack_en so the master owns that slot
                    sda_oe <= ack_en;
                end else if (tx_en) begin
                    sda_oe <= !sh[7];
                    sh <= {sh[6:0], 1'b0};
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** design/i2c_tac_defs.svh ***
`ifndef I2C_TAC_DEFS_SVH
`define I2C_TAC_DEFS_SVH

// Register offsets (byte addresses)
`define I2C_TAC_CTRL_OFFSET 8'h00
`define I2C_TAC_STATUS_OFFSET 8'h04

// Control register field positions, LSB-zero numbering
`define I2C_TAC_RD_EN_BIT 31
`define I2C_TAC_WR_EN_BIT 30
`define I2C_TAC_ALERT_EN_BIT 29
`define I2C_TAC_ENABLE_BIT 28
`define I2C_TAC_UNLOCK_BIT 24
`define I2C_TAC_ADDR_MSB 6
`define I2C_TAC_ADDR_LSB 0

// Status register field positions
`define I2C_TAC_ST_ALERT_BIT 0
`define I2C_TAC_ST_STRAP_LSB 1
`define I2C_TAC_ST_STRAP_MSB 2
`define I2C_TAC_ST_LAST_READ_BIT 3

// Reset values
`define I2C_TAC_RD_EN_RST 1'b1
`define I2C_TAC_WR_EN_RST 1'b1
`define I2C_TAC_ALERT_EN_RST 1'b0
`define I2C_TAC_ENABLE_RST 1'b1
`define I2C_TAC_UNLOCK_RST 1'b0
`define I2C_TAC_ADDR_RST 7'h30

// Special bus addresses
`define I2C_TAC_ALERT_ADDR 7'h0c
`define I2C_TAC_GENERAL_ADDR 7'h00

`endif

// *** design/i2c_tac_pkg.sv ***
package i2c_tac_pkg;

    typedef enum logic [2:0] {
        I2C_TAC_IDLE,
        I2C_TAC_ADDR,
        I2C_TAC_ACCESS_WR,
        I2C_TAC_ACCESS_RD,
        I2C_TAC_ALERT_TX,
        I2C_TAC_IGNORE
    } i2c_tac_state_e;

    typedef logic [6:0] i2c_tac_addr_t;

endpackage

// *** design/i2c_tac_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module i2c_tac_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

`default_nettype wire

// *** design/i2c_tac_top.sv ***
// Function
// [RULE_01] Enabled: acknowledge our programmed bus address
// [RULE_02] Disabled: NACK all but alert read
// [RULE_03] Disable also blocks internal register access
// [RULE_04] Internal access needs enable plus read/write
// [RULE_05] Locked: writes keep two low bits
// [RULE_06] Low bits change only with unlock set
// [RULE_07] Seven bit address field, resets to 0x30
// [RULE_08] Low address bits latched from pins
// [RULE_09] Software never programs address zero
// [RULE_10] General call ignored and NACKed
// [RULE_11] Alert read returns address, clears flag
// [RULE_12] Alert response wins over own address
// [RULE_13] Decide acknowledge in address byte slot
`include "i2c_tac_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module i2c_tac_top #(
    parameter int AW = 8
) (
    input wire logic mclk,
    input wire logic lclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [1:0] addr_strap,
    input wire logic alert_event,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic internal_read_allow,
    output logic internal_write_allow,
    output logic peripheral_allow,
    output logic access_start,
    output logic access_read
);
    import i2c_tac_pkg::*;

    // ---------------- Device clock domain ----------------
    logic rst_sys_n;
    logic [1:0] strap_s;
    logic strap_done;
    logic [1:0] strap_val;
    logic internal_read_enable;
    logic internal_write_enable;
    logic alert_response_enable;
    logic target_enable;
    logic address_low_bits_unlock;
    i2c_tac_pkg::i2c_tac_addr_t target_bus_address;
    logic alert_flag;
    logic last_read;
    logic [8:0] cfg_hold;
    logic cfg_req;
    logic [2:0] back_s;
    logic served_q;
    logic acc_q;
    logic wr_ctrl;

    // Lane image of the control register, MSB-zero fields mapped to LSB-zero
    function automatic logic [31:0] ctrl_image(input logic rde, input logic wre,
                                                input logic ale, input logic ena,
                                                input logic unl, input logic [6:0] adr);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`I2C_TAC_RD_EN_BIT] = rde;
        v[`I2C_TAC_WR_EN_BIT] = wre;
        v[`I2C_TAC_ALERT_EN_BIT] = ale;
        v[`I2C_TAC_ENABLE_BIT] = ena;
        v[`I2C_TAC_UNLOCK_BIT] = unl;
        v[`I2C_TAC_ADDR_MSB:`I2C_TAC_ADDR_LSB] = adr;
        return v;
    endfunction

    i2c_tac_sync #(.W(1)) u_rst_sys (
        .clk(mclk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_sys_n)
    );

    // Strap sync runs from raw reset so it is valid when the core leaves reset
    i2c_tac_sync #(.W(2)) u_strap (
        .clk(mclk),
        .rst_n(rst_n),
        .d(addr_strap),
        .q(strap_s)
    );

    assign wr_ctrl = reg_wr && (reg_addr == AW'(`I2C_TAC_CTRL_OFFSET));

    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            internal_read_enable <= `I2C_TAC_RD_EN_RST;
            internal_write_enable <= `I2C_TAC_WR_EN_RST;
            alert_response_enable <= `I2C_TAC_ALERT_EN_RST;
            target_enable <= `I2C_TAC_ENABLE_RST;
            address_low_bits_unlock <= `I2C_TAC_UNLOCK_RST;
            target_bus_address <= `I2C_TAC_ADDR_RST; // RULE_07
            strap_done <= 1'b0;
            strap_val <= 2'h0;
        end else if (ce) begin
            if (!strap_done) begin
                target_bus_address[1:0] <= strap_s; // RULE_08
                strap_val <= strap_s;
                strap_done <= 1'b1;
            end
            if (wr_ctrl) begin
                internal_read_enable <= reg_wdata[`I2C_TAC_RD_EN_BIT];
                internal_write_enable <= reg_wdata[`I2C_TAC_WR_EN_BIT];
                alert_response_enable <= reg_wdata[`I2C_TAC_ALERT_EN_BIT];
                target_enable <= reg_wdata[`I2C_TAC_ENABLE_BIT];
                address_low_bits_unlock <= reg_wdata[`I2C_TAC_UNLOCK_BIT];
                target_bus_address[6:2] <= reg_wdata[`I2C_TAC_ADDR_MSB:2];
                // Unlock must travel in the same write as the new low bits
                if (reg_wdata[`I2C_TAC_UNLOCK_BIT]) begin
                    target_bus_address[1:0] <= reg_wdata[1:0]; // RULE_05 RULE_06
                end
            end
        end
    end

    // Flag cleared by the link after an alert response; a new event wins
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            alert_flag <= 1'b0;
            served_q <= 1'b0;
        end else if (ce) begin
            served_q <= back_s[1];
            if (alert_event) begin
                alert_flag <= 1'b1;
            end else if (back_s[1] != served_q) begin
                alert_flag <= 1'b0; // RULE_11
            end
        end
    end

    // Register read port: data valid only the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd && reg_addr == AW'(`I2C_TAC_CTRL_OFFSET)) begin
                reg_rdata <= ctrl_image(internal_read_enable, internal_write_enable,
                                        alert_response_enable, target_enable,
                                        address_low_bits_unlock, target_bus_address);
            end else if (reg_rd && reg_addr == AW'(`I2C_TAC_STATUS_OFFSET)) begin
                reg_rdata[`I2C_TAC_ST_ALERT_BIT] <= alert_flag;
                reg_rdata[`I2C_TAC_ST_STRAP_MSB:`I2C_TAC_ST_STRAP_LSB] <= strap_val;
                reg_rdata[`I2C_TAC_ST_LAST_READ_BIT] <= last_read;
            end
        end
    end

    // Access gating towards the internal register mailbox
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            internal_read_allow <= 1'b0;
            internal_write_allow <= 1'b0;
            peripheral_allow <= 1'b0;
        end else if (ce) begin
            internal_read_allow <= target_enable && internal_read_enable; // RULE_03 RULE_04
            internal_write_allow <= target_enable && internal_write_enable; // RULE_03 RULE_04
            peripheral_allow <= target_enable; // RULE_04
        end
    end

    // Config handshake: launch a new word only once the last one is taken
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            cfg_hold <= {`I2C_TAC_ENABLE_RST, `I2C_TAC_ALERT_EN_RST, `I2C_TAC_ADDR_RST};
            cfg_req <= 1'b0;
        end else if (ce) begin
            if (cfg_req == back_s[0] &&
                cfg_hold != {target_enable, alert_response_enable, target_bus_address}) begin
                cfg_hold <= {target_enable, alert_response_enable, target_bus_address};
                cfg_req <= !cfg_req;
            end
        end
    end

    // ---------------- Link clock domain ----------------
    logic rst_link_n;
    logic [4:0] link_s;
    logic scl_s;
    logic sda_s;
    logic ce_l;
    logic alert_flag_l;
    logic req_s;
    logic cfg_seen;
    logic cfg_en_l;
    logic cfg_alert_l;
    logic [6:0] cfg_addr_l;
    i2c_tac_state_e state;
    logic ack_en;
    logic tx_en;
    logic [7:0] tx_data;
    logic served_tgl;
    logic acc_tgl;
    logic acc_rw_l;
    logic start_p;
    logic stop_p;
    logic byte_p;
    logic slot_end_p;
    logic [7:0] rx_byte;
    logic [6:0] rx_addr;
    logic rx_rw;

    i2c_tac_sync #(.W(1)) u_rst_link (
        .clk(lclk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_link_n)
    );

    i2c_tac_sync #(.W(5)) u_link_in (
        .clk(lclk),
        .rst_n(rst_n),
        .d({scl_i, sda_i, ce, alert_flag, cfg_req}),
        .q(link_s)
    );

    assign scl_s = link_s[4];
    assign sda_s = link_s[3];
    assign ce_l = link_s[2];
    assign alert_flag_l = link_s[1];
    assign req_s = link_s[0];
    assign rx_addr = rx_byte[7:1];
    assign rx_rw = rx_byte[0];

    always_ff @(posedge lclk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            cfg_seen <= 1'b0;
            cfg_en_l <= `I2C_TAC_ENABLE_RST;
            cfg_alert_l <= `I2C_TAC_ALERT_EN_RST;
            cfg_addr_l <= `I2C_TAC_ADDR_RST;
        end else if (req_s != cfg_seen) begin
            // Held word is stable while the request toggle is outstanding
            cfg_seen <= req_s;
            cfg_en_l <= cfg_hold[8];
            cfg_alert_l <= cfg_hold[7];
            cfg_addr_l <= cfg_hold[6:0];
        end
    end

    i2c_tac_bytes u_bytes (
        .clk(lclk),
        .rst_n(rst_link_n),
        .run(ce_l),
        .scl(scl_s),
        .sda(sda_s),
        .ack_en(ack_en),
        .tx_en(tx_en),
        .tx_data(tx_data),
        .start_p(start_p),
        .stop_p(stop_p),
        .byte_p(byte_p),
        .slot_end_p(slot_end_p),
        .master_nack(),
        .rx_byte(rx_byte),
        .sda_oe(sda_oe)
    );

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;

    always_ff @(posedge lclk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            state <= I2C_TAC_IDLE;
            ack_en <= 1'b0;
            tx_en <= 1'b0;
            tx_data <= 8'hff;
            served_tgl <= 1'b0;
            acc_tgl <= 1'b0;
            acc_rw_l <= 1'b0;
        end else if (ce_l) begin
            if (start_p) begin
                state <= I2C_TAC_ADDR;
                ack_en <= 1'b0;
                tx_en <= 1'b0;
            end else if (stop_p) begin
                state <= I2C_TAC_IDLE;
                ack_en <= 1'b0;
                tx_en <= 1'b0;
            end else if (byte_p) begin
                unique case (state)
                    I2C_TAC_ADDR: begin
                        // RULE_13
                        if (cfg_alert_l && rx_rw && alert_flag_l &&
                            rx_addr == `I2C_TAC_ALERT_ADDR) begin
                            state <= I2C_TAC_ALERT_TX; // RULE_02 RULE_12
                            ack_en <= 1'b1;
                            tx_en <= 1'b1;
                            tx_data <= {cfg_addr_l, 1'b0}; // RULE_11
                        end else if (rx_addr == `I2C_TAC_GENERAL_ADDR) begin
                            state <= I2C_TAC_IGNORE; // RULE_10
                            ack_en <= 1'b0;
                        end else if (cfg_alert_l && rx_addr == `I2C_TAC_ALERT_ADDR) begin
                            state <= I2C_TAC_IGNORE; // RULE_12
                            ack_en <= 1'b0;
                        end else if (cfg_en_l && rx_addr == cfg_addr_l) begin
                            state <= rx_rw ? I2C_TAC_ACCESS_RD : I2C_TAC_ACCESS_WR; // RULE_01
                            ack_en <= 1'b1;
                            acc_rw_l <= rx_rw;
                            acc_tgl <= !acc_tgl;
                        end else begin
                            state <= I2C_TAC_IGNORE; // RULE_02
                            ack_en <= 1'b0;
                        end
                    end
                    I2C_TAC_ALERT_TX: begin
                        // Single byte answer; flag cleared once it has gone out
                        state <= I2C_TAC_IGNORE;
                        tx_en <= 1'b0;
                        ack_en <= 1'b0;
                        served_tgl <= !served_tgl; // RULE_11
                    end
                    I2C_TAC_ACCESS_WR: ack_en <= 1'b1;
                    I2C_TAC_IDLE,
                    I2C_TAC_ACCESS_RD,
                    I2C_TAC_IGNORE: ack_en <= 1'b0;
                endcase
            end else if (slot_end_p) begin
                ack_en <= 1'b0;
            end
        end
    end

    // ---------------- Back to the device clock ----------------
    i2c_tac_sync #(.W(3)) u_back (
        .clk(mclk),
        .rst_n(rst_n),
        .d({acc_tgl, served_tgl, cfg_seen}),
        .q(back_s)
    );

    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            acc_q <= 1'b0;
            access_start <= 1'b0;
            access_read <= 1'b0;
            last_read <= 1'b0;
        end else if (ce) begin
            acc_q <= back_s[2];
            access_start <= back_s[2] != acc_q;
            // Direction bit is held steady long before its toggle lands here
            if (back_s[2] != acc_q) begin
                access_read <= acc_rw_l;
                last_read <= acc_rw_l;
            end
        end
    end
endmodule

`default_nettype wire
